// ---- cer_cal_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "cer_params.svh"
module cer_cal_regs
    import cer_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic raw_valid,
    input wire logic signed [15:0] raw_data,
    output logic signed [15:0] out_data,
    output logic out_valid,
    output logic conversion_ready_n,
    input wire logic serial_out_bit,
    output logic shared_out_ready_pin,
    output logic [2:0] current_magnitude,
    output logic [7:0] source1_ain,
    output logic excitation_pin_a_s1,
    output logic excitation_pin_b_s1,
    output logic [7:0] source2_ain,
    output logic excitation_pin_a_s2,
    output logic excitation_pin_b_s2
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [23:0] ofs_reg, ofs_next;
    logic [23:0] gain_reg, gain_next;
    logic [3:0] ctrl_reg, ctrl_next;
    logic [7:0] route_reg, route_next;
    logic [7:0] rdata_reg, rdata_next;

    // byte write into a 24-bit word, low byte at lowest address
    function automatic logic [23:0] put_byte(input logic [23:0] w, input logic [1:0] idx,
                                              input logic [7:0] b);
        logic [23:0] r;
        r = w;
        case (idx)
            2'd0: r[7:0] = b;
            2'd1: r[15:8] = b;
            default: r[23:16] = b;
        endcase
        return r;
    endfunction : put_byte

    // write decode
    always_comb begin
        ofs_next = ofs_reg;
        gain_next = gain_reg;
        ctrl_next = ctrl_reg;
        route_next = route_reg;
        if (reg_wr) begin
            case (reg_addr)
                `CER_ADDR_OFS0: ofs_next = put_byte(ofs_reg, 2'd0, reg_wdata);
                `CER_ADDR_OFS1: ofs_next = put_byte(ofs_reg, 2'd1, reg_wdata);
                `CER_ADDR_OFS2: ofs_next = put_byte(ofs_reg, 2'd2, reg_wdata);
                `CER_ADDR_GAIN0: gain_next = put_byte(gain_reg, 2'd0, reg_wdata);
                `CER_ADDR_GAIN1: gain_next = put_byte(gain_reg, 2'd1, reg_wdata);
                `CER_ADDR_GAIN2: gain_next = put_byte(gain_reg, 2'd2, reg_wdata);
                `CER_ADDR_CTRL: ctrl_next = reg_wdata[3:0];
                `CER_ADDR_ROUTE: route_next = reg_wdata;
                default: ;
            endcase
        end
    end

    // read decode, unmapped reads zero, data one cycle later
    always_comb begin
        rdata_next = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                `CER_ADDR_OFS0: rdata_next = ofs_reg[7:0];
                `CER_ADDR_OFS1: rdata_next = ofs_reg[15:8];
                `CER_ADDR_OFS2: rdata_next = ofs_reg[23:16];
                `CER_ADDR_GAIN0: rdata_next = gain_reg[7:0];
                `CER_ADDR_GAIN1: rdata_next = gain_reg[15:8];
                `CER_ADDR_GAIN2: rdata_next = gain_reg[23:16];
                `CER_ADDR_CTRL: rdata_next = {`CER_REVISION, ctrl_reg};
                `CER_ADDR_ROUTE: rdata_next = route_reg;
                default: rdata_next = 8'h00;
            endcase
        end
    end

    // register storage
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ofs_reg <= `CER_OFS_RESET;
            gain_reg <= `CER_GAIN_RESET;
            ctrl_reg <= `CER_CTRL_RESET;
            route_reg <= `CER_ROUTE_RESET;
            rdata_reg <= 8'h00;
        end else begin
            ofs_reg <= ofs_next;
            gain_reg <= gain_next;
            ctrl_reg <= ctrl_next;
            route_reg <= route_next;
            rdata_reg <= rdata_next;
        end
    end

    // ------------------------------------------------------------
    // correction pipeline
    // ------------------------------------------------------------
    cer_state_t st_reg, st_next;
    logic signed [25:0] diff_reg, diff_next;
    logic signed [50:0] prod_reg, prod_next;
    logic signed [15:0] outd_reg, outd_next;
    logic ov_reg, ov_next;
    logic rdy_n_reg, rdy_n_next;
    logic signed [28:0] scaled;

    // product back to output codes: drop 8 fraction bits and the 2^22 unity gain
    always_comb begin
        scaled = 29'(signed'(prod_reg[50:30]));
    end

    always_comb begin
        st_next = st_reg;
        diff_next = diff_reg;
        prod_next = prod_reg;
        outd_next = outd_reg;
        ov_next = 1'b0;
        rdy_n_next = rdy_n_reg;
        case (st_reg)
            CER_IDLE: begin
                if (raw_valid) begin
                    // raw code gets 8 fraction bits to meet the sub-code offset
                    diff_next = 26'(signed'({raw_data, 8'h00})) - 26'(signed'(ofs_reg));
                    st_next = CER_SUB;
                end
            end
            CER_SUB: begin
                prod_next = 51'(diff_reg) * 51'(signed'({1'b0, gain_reg}));
                st_next = CER_MUL;
            end
            CER_MUL: begin
                if (scaled > 29'(`CER_OUT_MAX)) outd_next = `CER_OUT_MAX;
                else if (scaled < 29'(`CER_OUT_MIN)) outd_next = `CER_OUT_MIN;
                else outd_next = scaled[15:0];
                st_next = CER_OUT;
            end
            CER_OUT: begin
                ov_next = 1'b1;
                rdy_n_next = 1'b0;
                st_next = CER_IDLE;
            end
            default: st_next = CER_IDLE;
        endcase
        // ready releases when software issues a read at any register address
        if (reg_rd && st_reg != CER_OUT) rdy_n_next = 1'b1;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_reg <= CER_IDLE;
            diff_reg <= '0;
            prod_reg <= '0;
            outd_reg <= 16'h0000;
            ov_reg <= 1'b0;
            rdy_n_reg <= 1'b1;
        end else begin
            st_reg <= st_next;
            diff_reg <= diff_next;
            prod_reg <= prod_next;
            outd_reg <= outd_next;
            ov_reg <= ov_next;
            rdy_n_reg <= rdy_n_next;
        end
    end

    // ------------------------------------------------------------
    // pins
    // ------------------------------------------------------------
    logic pin_reg, pin_next;

    // shared pin: data only, or data merged with ready while idle-high
    always_comb begin
        pin_next = serial_out_bit;
        if (ctrl_reg[3] && rdy_n_next) pin_next = 1'b1;
        if (ctrl_reg[3] && !rdy_n_next && !reg_rd) pin_next = 1'b0;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) pin_reg <= 1'b1;
        else pin_reg <= pin_next;
    end

    // magnitude is a plain field; the host keeps the reference on first
    assign current_magnitude = ctrl_reg[2:0];

    cer_route_decode u_src1 (
        .clk(clk),
        .rst_n(rst_n),
        .route(route_reg[7:4]),
        .ain_sel(source1_ain),
        .pin_a_sel(excitation_pin_a_s1),
        .pin_b_sel(excitation_pin_b_s1)
    );

    cer_route_decode u_src2 (
        .clk(clk),
        .rst_n(rst_n),
        .route(route_reg[3:0]),
        .ain_sel(source2_ain),
        .pin_a_sel(excitation_pin_a_s2),
        .pin_b_sel(excitation_pin_b_s2)
    );

    assign reg_rdata = rdata_reg;
    assign out_data = outd_reg;
    assign out_valid = ov_reg;
    assign conversion_ready_n = rdy_n_reg;
    assign shared_out_ready_pin = pin_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_ofs_write;
        @(posedge clk) disable iff (!rst_n)
        reg_wr && reg_addr == `CER_ADDR_OFS0 |=> ofs_reg[7:0] == $past(reg_wdata);
    endproperty
    a_ofs_write: assert property (p_ofs_write) else $error("offset low byte not stored");
    property p_gain_read;
        @(posedge clk) disable iff (!rst_n)
        reg_rd && reg_addr == `CER_ADDR_GAIN2 |=> reg_rdata == $past(gain_reg[23:16]);
    endproperty
    a_gain_read: assert property (p_gain_read) else $error("gain high byte read wrong");
    property p_rev_ro;
        @(posedge clk) disable iff (!rst_n)
        reg_rd && reg_addr == `CER_ADDR_CTRL |=> reg_rdata[7:4] == `CER_REVISION;
    endproperty
    a_rev_ro: assert property (p_rev_ro) else $error("revision field changed");
    property p_unity;
        @(posedge clk) disable iff (!rst_n)
        raw_valid && st_reg == CER_IDLE && ofs_reg == 24'h00_0000 ##1 gain_reg == `CER_GAIN_RESET
            |-> ##3 out_valid && out_data == $past(raw_data, 4);
    endproperty
    a_unity: assert property (p_unity) else $error("unity gain changes data");
    property p_latency;
        @(posedge clk) disable iff (!rst_n)
        raw_valid && st_reg == CER_IDLE |-> ##4 out_valid;
    endproperty
    a_latency: assert property (p_latency) else $error("result not delivered in 4 cycles");
    property p_ready;
        @(posedge clk) disable iff (!rst_n)
        out_valid |-> !conversion_ready_n;
    endproperty
    a_ready: assert property (p_ready) else $error("ready not low with new data");
    property p_clip;
        @(posedge clk) disable iff (!rst_n)
        st_reg == CER_MUL && scaled > 29'(`CER_OUT_MAX) |=> out_data == `CER_OUT_MAX;
    endproperty
    a_clip: assert property (p_clip) else $error("positive result not clipped");
    property p_share_off;
        @(posedge clk) disable iff (!rst_n)
        rst_n && !ctrl_reg[3] |=> shared_out_ready_pin == $past(serial_out_bit);
    endproperty
    a_share_off: assert property (p_share_off) else $error("pin not pure data");
    property p_route_open;
        @(posedge clk) disable iff (!rst_n)
        route_reg[7:6] == 2'b11 ##1 route_reg[7:6] == 2'b11 |-> source1_ain == 8'h00 && !excitation_pin_a_s1;
    endproperty
    a_route_open: assert property (p_route_open) else $error("source one not open");
    property p_route_pin_b;
        @(posedge clk) disable iff (!rst_n)
        route_reg[3:2] == 2'b10 && route_reg[0] |=> excitation_pin_b_s2;
    endproperty
    a_route_pin_b: assert property (p_route_pin_b) else $error("source two pin b not routed");
endmodule : cer_cal_regs
`default_nettype wire

// ---- cer_params.svh ----
// Behaviour
// - The offset coefficient is a 24-bit two's-complement value in three byte registers, low byte first, reset zero.
// - Its upper sixteen bits span full scale and its low eight bits give a sub-code fractional correction.
// - The offset coefficient is subtracted from each raw result before gain correction.
// - The gain coefficient is a 24-bit unsigned value reset to 400000h and divided by 400000h to form the scale.
// - The offset-corrected result is multiplied by the scale factor to form the output word.
// - Offset bytes sit at 04h-06h and gain bytes at 07h-09h, bits 7:0 at the first address.
// - Bits 7:4 of the control register return a fixed read-only revision code.
// - Bit 3 of the control register, reset 0, makes the data-out pin also signal data ready, active low.
// - The dedicated active-low ready output always indicates new data whatever the sharing bit holds.
// - Bits 2:0 set both excitation current magnitudes, off at reset, 50 to 1500 microamperes.
// - Bits 7:4 of the routing register steer source one: inputs 0-7, pin a, pin b or disconnected, reset Fh.
// - Bits 3:0 of the routing register steer source two with the same map, reset Fh.
// - The control register sits at 0Ah and the routing register at 0Bh, which resets to FFh.
`ifndef CER_PARAMS_SVH
`define CER_PARAMS_SVH
`define CER_ADDR_OFS0 8'h04
`define CER_ADDR_OFS1 8'h05
`define CER_ADDR_OFS2 8'h06
`define CER_ADDR_GAIN0 8'h07
`define CER_ADDR_GAIN1 8'h08
`define CER_ADDR_GAIN2 8'h09
`define CER_ADDR_CTRL 8'h0a
`define CER_ADDR_ROUTE 8'h0b
`define CER_OFS_RESET 24'h00_0000
`define CER_GAIN_RESET 24'h40_0000
`define CER_GAIN_SHIFT 22
`define CER_CTRL_RESET 4'h0
`define CER_ROUTE_RESET 8'hff
`define CER_REVISION 4'h5
`define CER_OUT_MAX 16'sh7fff
`define CER_OUT_MIN 16'sh8000
`endif

// ---- cer_pkg.sv ----
package cer_pkg;
    // state of the correction pipeline
    typedef enum logic [1:0] {
        CER_IDLE = 2'b00,
        CER_SUB = 2'b01,
        CER_MUL = 2'b10,
        CER_OUT = 2'b11
    } cer_state_t;
    // decoded target of one excitation source
    typedef enum logic [1:0] {
        CER_TGT_AIN = 2'b00,
        CER_TGT_PIN_A = 2'b01,
        CER_TGT_PIN_B = 2'b10,
        CER_TGT_OPEN = 2'b11
    } cer_target_t;
endpackage : cer_pkg

// ---- cer_route_decode.sv ----
`timescale 1ns/1ps
`default_nettype none
// decodes one 4-bit route code into a registered steering set, one-hot, or all zero for an open code
module cer_route_decode
    import cer_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] route,
    output logic [7:0] ain_sel,
    output logic pin_a_sel,
    output logic pin_b_sel
);
    logic [7:0] ain_reg, ain_next;
    logic pa_reg, pa_next, pb_reg, pb_next;
    cer_target_t tgt;

    // code map: 0xxx input, 10x0 pin a, 10x1 pin b, 11xx open
    always_comb begin
        if (!route[3]) tgt = CER_TGT_AIN;
        else if (route[2]) tgt = CER_TGT_OPEN;
        else if (route[0]) tgt = CER_TGT_PIN_B;
        else tgt = CER_TGT_PIN_A;
        ain_next = 8'h00;
        if (tgt == CER_TGT_AIN) ain_next[route[2:0]] = 1'b1;
        pa_next = (tgt == CER_TGT_PIN_A);
        pb_next = (tgt == CER_TGT_PIN_B);
    end

    // register the steering, all open at reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ain_reg <= 8'h00;
            pa_reg <= 1'b0;
            pb_reg <= 1'b0;
        end else begin
            ain_reg <= ain_next;
            pa_reg <= pa_next;
            pb_reg <= pb_next;
        end
    end

    assign ain_sel = ain_reg;
    assign pin_a_sel = pa_reg;
    assign pin_b_sel = pb_reg;
endmodule : cer_route_decode
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "cer_params.svh"
module tb_top
    import cer_pkg::*;
;
    // ----------------------------------------
    // clock, reset and design hookup
    // ----------------------------------------
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic raw_valid = 1'b0;
    logic signed [15:0] raw_data = 16'sh0000;
    logic signed [15:0] out_data;
    logic out_valid;
    logic conversion_ready_n;
    logic serial_out_bit = 1'b0;
    logic shared_out_ready_pin;
    logic [2:0] current_magnitude;
    logic [7:0] source1_ain, source2_ain;
    logic excitation_pin_a_s1, excitation_pin_b_s1, excitation_pin_a_s2, excitation_pin_b_s2;
    int fail_count = 0;
    int total_checks = 0;

    // 20 MHz clock
    always #25 clk = ~clk;

    cer_cal_regs u_cer_cal_regs (
        .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .raw_valid(raw_valid), .raw_data(raw_data), .out_data(out_data), .out_valid(out_valid),
        .conversion_ready_n(conversion_ready_n), .serial_out_bit(serial_out_bit),
        .shared_out_ready_pin(shared_out_ready_pin), .current_magnitude(current_magnitude),
        .source1_ain(source1_ain), .excitation_pin_a_s1(excitation_pin_a_s1),
        .excitation_pin_b_s1(excitation_pin_b_s1), .source2_ain(source2_ain),
        .excitation_pin_a_s2(excitation_pin_a_s2), .excitation_pin_b_s2(excitation_pin_b_s2)
    );

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    // compare one value and count it
    task automatic chk(input string name, input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // verdict and end of run
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict

    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    // one-cycle read strobe, data checked in the following cycle
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk("reg_rdata", {16'h0000, reg_rdata}, {16'h0000, exp});
    endtask : rd

    // three bytes, low byte at the lowest address, then read back
    task automatic wr24(input logic [7:0] base, input logic [23:0] v);
        wr(base, v[7:0]);
        wr(base + 8'h01, v[15:8]);
        wr(base + 8'h02, v[23:16]);
        rd(base, v[7:0]);
        rd(base + 8'h01, v[15:8]);
        rd(base + 8'h02, v[23:16]);
    endtask : wr24

    // expected result: offset removed, scaled by gain/400000h, clipped
    function automatic logic [15:0] model(input longint raw, input longint ofs, input longint gain);
        longint v;
        v = ((raw * 256 - ofs) * gain) >>> 30;
        if (v > 32767) v = 32767;
        if (v < -32768) v = -32768;
        return v[15:0];
    endfunction : model

    // expected steering {ain, pin a, pin b} for one route code
    function automatic logic [9:0] route_exp(input logic [3:0] c);
        if (c[3] == 1'b0) return {8'h01 << c[2:0], 2'b00};
        if (c[2] == 1'b1) return 10'h000;
        return c[0] ? 10'h001 : 10'h002;
    endfunction : route_exp

    // one raw sample, bounded wait for the result
    task automatic convert(input logic signed [15:0] raw, input logic [15:0] exp);
        int n;
        @(posedge clk);
        raw_valid <= 1'b1;
        raw_data <= raw;
        @(posedge clk);
        raw_valid <= 1'b0;
        #1;
        n = 0;
        while (out_valid !== 1'b1 && n < 8) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("out_valid", {23'h0, out_valid}, 24'h00_0001);
        chk("out_data", {8'h00, out_data}, {8'h00, exp});
        @(posedge clk);
        #1;
        chk("ready_n", {23'h0, conversion_ready_n}, 24'h00_0000);
    endtask : convert

    // ----------------------------------------
    // watchdog
    // ----------------------------------------
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        print_verdict();
    end

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        static longint ofs_t[6] = '{0, 256, 128, 0, -512, 0};
        static longint gain_t[6] = '{24'h40_0000, 24'h40_0000, 24'h40_0000, 24'h20_0000, 24'h7f_ffff, 24'h7f_ffff};
        static longint raw_t[6] = '{1234, 100, 10, -1000, 30000, -30000};
        logic [9:0] r1, r2;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        // reset values and unmapped places
        rd(8'h04, 8'h00);
        rd(8'h05, 8'h00);
        rd(8'h06, 8'h00);
        rd(8'h07, 8'h00);
        rd(8'h08, 8'h00);
        rd(8'h09, 8'h40);
        rd(8'h0a, {`CER_REVISION, 4'h0});
        rd(8'h0b, 8'hff);
        rd(8'h00, 8'h00);
        rd(8'h3c, 8'h00);
        chk("ready_n", {23'h0, conversion_ready_n}, 24'h00_0001);
        chk("s1", {14'h0, source1_ain, excitation_pin_a_s1, excitation_pin_b_s1}, 24'h0);
        chk("s2", {14'h0, source2_ain, excitation_pin_a_s2, excitation_pin_b_s2}, 24'h0);
        // revision is read-only, magnitude codes all reach the pins
        for (int m = 0; m < 8; m++) begin
            wr(8'h0a, {4'ha, 1'b0, m[2:0]});
            rd(8'h0a, {`CER_REVISION, 1'b0, m[2:0]});
            chk("magnitude", {21'h0, current_magnitude}, {21'h0, m[2:0]});
        end
        wr(8'h0a, 8'h00);
        // every route code on both sources
        for (int c = 0; c < 16; c++) begin
            wr(8'h0b, {c[3:0], ~c[3:0]});
            repeat (2) @(posedge clk);
            #1;
            r1 = route_exp(c[3:0]);
            r2 = route_exp(~c[3:0]);
            chk("s1", {14'h0, source1_ain, excitation_pin_a_s1, excitation_pin_b_s1}, {14'h0, r1});
            chk("s2", {14'h0, source2_ain, excitation_pin_a_s2, excitation_pin_b_s2}, {14'h0, r2});
        end
        rd(8'h0b, 8'hf0);
        // pin sharing off: pin follows serial data only
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            serial_out_bit <= i[0];
            @(posedge clk);
            #1;
            chk("shared_pin", {23'h0, shared_out_ready_pin}, {23'h0, i[0]});
        end
        // corrected conversions, with the data ready merged on the pin
        wr(8'h0a, 8'h08);
        serial_out_bit <= 1'b0;
        for (int k = 0; k < 6; k++) begin
            wr24(8'h04, ofs_t[k][23:0]);
            wr24(8'h07, gain_t[k][23:0]);
            convert(raw_t[k][15:0], model(raw_t[k], ofs_t[k], gain_t[k]));
            chk("shared_pin", {23'h0, shared_out_ready_pin}, 24'h00_0000);
            rd(8'h0a, {`CER_REVISION, 4'h8});
            @(posedge clk);
            #1;
            chk("ready_n", {23'h0, conversion_ready_n}, 24'h00_0001);
            chk("shared_pin", {23'h0, shared_out_ready_pin}, 24'h00_0001);
        end
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
